// File: hdl/mode_ctrl_defs.svh
// mode control serial port: offsets, encodings and timing counts
// assumes inclusion by bare name from the package and the modules
`ifndef MODE_CTRL_DEFS_SVH
`define MODE_CTRL_DEFS_SVH

// system clock period in ns (20 MHz)
`define CLK_PERIOD_NS 50
// command word width and mode field position
`define CMD_WIDTH 8
`define MODE_MSB 2
`define MODE_LSB 0
// mode codes
`define MODE_SHUTDOWN 3'h0
`define MODE_IDLE 3'h1
`define MODE_RX 3'h2
`define MODE_TX 3'h3
`define MODE_XCVR 3'h4
`define MODE_STANDBY 3'h5
// mode held after reset until the host programs one
`define MODE_RESET 3'h0
// recovery times in us
`define T_FAST_US 10
`define T_SLOW_US 40
// cycle counts, longest times round down
`define T_FAST_CYC ((`T_FAST_US * 1000) / `CLK_PERIOD_NS)
`define T_SLOW_CYC ((`T_SLOW_US * 1000) / `CLK_PERIOD_NS)
// width of the recovery counter
`define WAKE_CNT_W 10
// converter clock considered static after this many cycles without edge
`define CONV_STATIC_CYC 10'h020

`endif

// File: hdl/mode_ctrl_pkg.sv
// mode control serial port: shared types
// assumes mode_ctrl_defs.svh on the include path
`include "mode_ctrl_defs.svh"

package mode_ctrl_pkg;

  // operating modes as held in the mode latch
  typedef enum logic [2:0] {
    MODE_SHUTDOWN_E = 3'h0,
    MODE_IDLE_E = 3'h1,
    MODE_RX_E = 3'h2,
    MODE_TX_E = 3'h3,
    MODE_XCVR_E = 3'h4,
    MODE_STANDBY_E = 3'h5
  } op_mode_type;

endpackage

// File: hdl/serial_shift_in.sv
// serial shift-in front end: synchronises select, serial clock and data,
// shifts msb first on serial clock rise, pulses a word on select rise
// assumes pins are asynchronous to clk and sclk is far slower than clk
`timescale 1ns/1ns
`include "mode_ctrl_defs.svh"

module serial_shift_in (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  // received command
  output logic [`CMD_WIDTH-1:0] word_r,
  output logic word_valid_r
);

  logic [1:0] cs_sync_r;
  logic [1:0] sclk_sync_r;
  logic [1:0] din_sync_r;
  logic cs_prev_r;
  logic sclk_prev_r;
  logic [`CMD_WIDTH-1:0] shift_r;
  logic [3:0] count_r;
  logic sclk_rise;
  logic cs_fall;
  logic cs_rise;

  // two-flop synchronisers, only stage one feeds stage two
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_sync_r <= 2'h3;
      sclk_sync_r <= 2'h0;
      din_sync_r <= 2'h0;
    end else begin
      cs_sync_r <= {cs_sync_r[0], cs_n};
      sclk_sync_r <= {sclk_sync_r[0], sclk};
      din_sync_r <= {din_sync_r[0], din};
    end
  end

  // edge history taken from the second stage only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_prev_r <= 1'h1;
      sclk_prev_r <= 1'h0;
    end else begin
      cs_prev_r <= cs_sync_r[1];
      sclk_prev_r <= sclk_sync_r[1];
    end
  end

  // sclk rising edge, cs falling and rising edges
  // idle level of sclk is never looked at, only its 0-to-1 change
  assign sclk_rise = sclk_sync_r[1] && !sclk_prev_r;
  assign cs_fall = !cs_sync_r[1] && cs_prev_r;
  assign cs_rise = cs_sync_r[1] && !cs_prev_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_r <= 8'h00;
      count_r <= 4'h0;
    end else if (cs_fall) begin
      count_r <= 4'h0;
    end else if (!cs_sync_r[1] && sclk_rise) begin
      shift_r <= {shift_r[`CMD_WIDTH-2:0], din_sync_r[1]};
      // saturate so extra bits keep the last eight
      if (count_r != 4'h8) begin
        count_r <= count_r + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      word_r <= 8'h00;
      word_valid_r <= 1'h0;
    end else begin
      word_valid_r <= cs_rise && (count_r == 4'h8);
      if (cs_rise && (count_r == 4'h8)) begin
        word_r <= shift_r;
      end
    end
  end

endmodule

// File: hdl/mode_control_serial_port.sv
// mode control serial port: command latch, mode decode, converter
// enables, adc output bus drive and wake-up / recovery timing
// assumes conv_clk and the serial pins are asynchronous to clk
//
// Overview of operation
// - 8-bit command, low three bits pick mode
// - serial port accepts writes in every mode
// - shutdown: reference, adcs, dacs off, bus floats
// - tx floats adc bus, rx stops dacs
// - bus re-driven starts with last converted word
// - leaving shutdown clears dac input registers
// - wake from shutdown rx/tx/xcvr 10/40/40 us
// - idle keeps reference and clock, 10 us
// - static converter clock in idle: 40 us
// - standby: adc reference only, 40 us
// - bits accepted only while select low
// - sample on serial clock rise, msb first
// - eight bits shifted in, low three move into the mode latch unless they are 6 or 7
// - serial clock idle level does not matter
// - mode acts and timing starts on select rise
// - switching among rx, tx, xcvr takes 10 us
// - shutdown or standby to xcvr takes 40 us
`timescale 1ns/1ns
`include "mode_ctrl_defs.svh"

module mode_control_serial_port (
  // system clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial command pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  // converter clock pin, watched for activity in idle
  input wire logic conv_clk,
  // latest converted word from the adc core
  input wire logic [7:0] adc_word,
  input wire logic adc_word_valid,
  // dac data from the pins
  input wire logic [9:0] dac_in,
  input wire logic dac_in_valid,
  // adc output bus, a data bit per pin and one shared output enable
  output logic [7:0] adc_out_bus_o,
  output logic adc_out_bus_oe,
  // power and enable controls
  output mode_ctrl_pkg::op_mode_type mode_r,
  output logic ref_on,
  output logic clk_dist_on,
  output logic adc_on,
  output logic dac_on,
  output logic conv_ready,
  output logic [9:0] dac_data_r
);

  import mode_ctrl_pkg::*;

  logic [`CMD_WIDTH-1:0] cmd_word;
  logic cmd_valid;
  logic [2:0] cmd_mode;
  logic mode_accept;
  logic [`WAKE_CNT_W-1:0] wait_cnt_r;
  logic [`WAKE_CNT_W-1:0] wait_nxt;
  logic [7:0] last_word_r;
  logic [1:0] cclk_sync_r;
  logic cclk_prev_r;
  logic [9:0] cclk_idle_r;
  logic conv_static;
  logic idle_static_r;

  ////////////////////////////////////////////////////////////////////////
  // serial front end

  // port always live
  // the shifter has no mode input, so shutdown cannot block it
  serial_shift_in u_shift (
    .clk(clk),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .sclk(sclk),
    .din(din),
    .word_r(cmd_word),
    .word_valid_r(cmd_valid)
  );

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  // true for the six defined mode codes
  function automatic logic mode_defined(input logic [2:0] code);
    mode_defined = (code <= `MODE_STANDBY);
  endfunction

  // true for the three active converter modes
  function automatic logic mode_active(input logic [2:0] code);
    mode_active = (code == `MODE_RX) || (code == `MODE_TX) ||
      (code == `MODE_XCVR);
  endfunction

  // true where the adc is running and drives its bus
  function automatic logic mode_adc(input logic [2:0] code);
    mode_adc = (code == `MODE_RX) || (code == `MODE_XCVR);
  endfunction

  // true where the dacs are running
  function automatic logic mode_dac(input logic [2:0] code);
    mode_dac = (code == `MODE_TX) || (code == `MODE_XCVR);
  endfunction

  assign cmd_mode = cmd_word[`MODE_MSB:`MODE_LSB];
  assign mode_accept = cmd_valid && mode_defined(cmd_mode);

  ////////////////////////////////////////////////////////////////////////
  // mode latch

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_r <= MODE_SHUTDOWN_E;
    end else if (mode_accept) begin
      mode_r <= op_mode_type'(cmd_mode);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // converter clock activity, used to stretch the idle wake-up

  // two-flop synchroniser for the converter clock pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cclk_sync_r <= 2'h0;
      cclk_prev_r <= 1'h0;
    end else begin
      cclk_sync_r <= {cclk_sync_r[0], conv_clk};
      cclk_prev_r <= cclk_sync_r[1];
    end
  end

  // count cycles since the last converter clock change
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cclk_idle_r <= 10'h000;
    end else if (cclk_sync_r[1] != cclk_prev_r) begin
      cclk_idle_r <= 10'h000;
    end else if (!conv_static) begin
      cclk_idle_r <= cclk_idle_r + 10'h001;
    end
  end

  assign conv_static = (cclk_idle_r >= `CONV_STATIC_CYC);

  // static clock in idle
  // remembered so a brief restart before wake still costs the long time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idle_static_r <= 1'h0;
    end else if (mode_r != MODE_IDLE_E) begin
      idle_static_r <= 1'h0;
    end else if (conv_static) begin
      idle_static_r <= 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wake-up and recovery interval

  // pick the interval for the pending transition
  always_comb begin
    wait_nxt = '0;
    if (mode_active(cmd_mode)) begin
      case (mode_r)
        MODE_SHUTDOWN_E: begin
          if (cmd_mode == `MODE_RX) begin
            wait_nxt = `WAKE_CNT_W'(`T_FAST_CYC);
          end else begin
            wait_nxt = `WAKE_CNT_W'(`T_SLOW_CYC);
          end
        end
        MODE_IDLE_E: begin
          if (idle_static_r || conv_static) begin
            wait_nxt = `WAKE_CNT_W'(`T_SLOW_CYC);
          end else begin
            wait_nxt = `WAKE_CNT_W'(`T_FAST_CYC);
          end
        end
        MODE_STANDBY_E: begin
          wait_nxt = `WAKE_CNT_W'(`T_SLOW_CYC);
        end
        MODE_RX_E, MODE_TX_E, MODE_XCVR_E: begin
          if (cmd_mode != 3'(mode_r)) begin
            wait_nxt = `WAKE_CNT_W'(`T_FAST_CYC);
          end
        end
        default: begin
          wait_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_cnt_r <= '0;
    end else if (mode_accept) begin
      wait_cnt_r <= wait_nxt;
    end else if (wait_cnt_r != '0) begin
      wait_cnt_r <= wait_cnt_r - `WAKE_CNT_W'(1);
    end
  end

  // converters valid once the interval has run out in an active mode
  assign conv_ready = mode_active(3'(mode_r)) && (wait_cnt_r == '0);

  ////////////////////////////////////////////////////////////////////////
  // power enables

  assign ref_on = (mode_r != MODE_SHUTDOWN_E);
  assign clk_dist_on = (mode_r != MODE_SHUTDOWN_E) &&
    (mode_r != MODE_STANDBY_E);
  assign adc_on = mode_adc(3'(mode_r));
  assign dac_on = mode_dac(3'(mode_r));

  ////////////////////////////////////////////////////////////////////////
  // adc output bus

  // hold last converted word
  // the word survives while the bus floats, so re-driving shows it first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last_word_r <= 8'h00;
    end else if (adc_word_valid && adc_on) begin
      last_word_r <= adc_word;
    end
  end

  assign adc_out_bus_oe = adc_on;
  assign adc_out_bus_o = last_word_r;

  ////////////////////////////////////////////////////////////////////////
  // dac input register

  // lose data after shutdown
  // only loaded while dacs run; inputs are don't-care otherwise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dac_data_r <= 10'h000;
    end else if (mode_accept && (mode_r == MODE_SHUTDOWN_E) &&
        (cmd_mode != `MODE_SHUTDOWN)) begin
      dac_data_r <= 10'h000;
    end else if (dac_on && dac_in_valid) begin
      dac_data_r <= dac_in;
    end
  end

endmodule

// File: sim/host_model.sv
// host model: writes mode commands over the 3-wire serial port
// assumes clk is the system clock; serial pins driven on its fall
`timescale 1ns/1ns

module host_model (
  // timing reference and idle level of the serial clock
  input wire logic clk,
  input wire logic sclk_idle,
  // serial pins
  output logic cs_n = 1'b1,
  output logic sclk = 1'b0,
  output logic din = 1'b0
);

  ////////////////////////////////////////////////////////////////////
  // select low, msb first, gap, idle
  // sclk period 8 clk (400 ns); din set while sclk low
  task wr(input logic [7:0] w, input int n);
    @(negedge clk) cs_n = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 7; i > 7 - n; i--) begin
      sclk = 1'b0;
      din = w[i];
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
    end
    cs_n = 1'b1;
    sclk = sclk_idle;
    // released data line shows no stale bit
    din = ~din;
    repeat (6) @(negedge clk);
  endtask

endmodule

// File: sim/mode_ctrl_chk.sv
// checker: mode decode, enables and mode timing at the top ports
// assumes binding to mode_control_serial_port
`timescale 1ns/1ns

module mode_ctrl_chk import mode_ctrl_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // watched ports
  input wire logic cs_n,
  input wire op_mode_type mode_r,
  input wire logic ref_on,
  input wire logic clk_dist_on,
  input wire logic adc_on,
  input wire logic dac_on,
  input wire logic adc_out_bus_oe,
  input wire logic conv_ready,
  input wire logic [9:0] dac_data_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_ref; ref_on == (mode_r != MODE_SHUTDOWN_E); endproperty
  a_ref: assert property (p_ref)
    else $error("reference enable wrong");
  property p_cdist;
    clk_dist_on == !(mode_r inside {MODE_SHUTDOWN_E, MODE_STANDBY_E});
  endproperty
  a_cdist: assert property (p_cdist)
    else $error("clock distribution wrong");
  property p_adc; adc_on == (mode_r inside {MODE_RX_E, MODE_XCVR_E});
  endproperty
  a_adc: assert property (p_adc)
    else $error("adc enable wrong");
  property p_dac; dac_on == (mode_r inside {MODE_TX_E, MODE_XCVR_E});
  endproperty
  a_dac: assert property (p_dac)
    else $error("dac enable wrong");
  property p_oe; adc_out_bus_oe == adc_on; endproperty
  a_oe: assert property (p_oe)
    else $error("adc bus drive wrong");
  property p_mch; $changed(mode_r) |-> cs_n && $past(cs_n, 3); endproperty
  a_mch: assert property (p_mch)
    else $error("mode changed while selected");
  property p_rdy;
    conv_ready |-> mode_r inside {MODE_RX_E, MODE_TX_E, MODE_XCVR_E};
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("ready in inactive mode");
  property p_wake;
    $past(mode_r) == MODE_SHUTDOWN_E && mode_r == MODE_XCVR_E
      |-> !conv_ready [*8];
  endproperty
  a_wake: assert property (p_wake)
    else $error("ready too early after wake");
  property p_dclr;
    $past(mode_r) == MODE_SHUTDOWN_E && mode_r != MODE_SHUTDOWN_E
      |-> dac_data_r == 10'h000;
  endproperty
  a_dclr: assert property (p_dclr)
    else $error("dac data kept after shutdown");
endmodule

bind mode_control_serial_port mode_ctrl_chk i_chk (.clk, .rst_n,
  .cs_n, .mode_r, .ref_on, .clk_dist_on, .adc_on, .dac_on,
  .adc_out_bus_oe, .conv_ready, .dac_data_r);

// File: sim/tb.sv
// testbench: mode commands, enables, adc bus and recovery times
// assumes host_model drives the serial pins
`timescale 1ns/1ns

module tb;
  import mode_ctrl_pkg::*;
  localparam int SLOW = 40000 / 50;
  localparam int FAST = 10000 / 50;
  logic clk = 1'b0, rst_n = 1'b0, conv_clk = 1'b0, run_cc = 1'b1;
  logic adc_word_valid = 1'b0, dac_in_valid = 1'b0, idle_hi = 1'b0;
  logic [7:0] adc_word = 8'h00, bus_o;
  logic [9:0] dac_in = 10'h000, dac_q;
  logic cs_n, sclk, din, oe, ref_on, cd_on, adc_on, dac_on, rdy;
  op_mode_type mode;
  int num_errors = 0, samples_checked = 0;

  ////////////////////////////////////////////////////////////////////
  // clocks; converter clock can be stopped to look static
  initial forever #25 clk = ~clk;
  always #100 if (run_cc) conv_clk = ~conv_clk;

  host_model h (.clk, .sclk_idle(idle_hi), .cs_n, .sclk, .din);
  mode_control_serial_port i_dut (.clk, .rst_n, .cs_n, .sclk, .din,
    .conv_clk, .adc_word, .adc_word_valid, .dac_in, .dac_in_valid,
    .adc_out_bus_o(bus_o), .adc_out_bus_oe(oe), .mode_r(mode),
    .ref_on, .clk_dist_on(cd_on), .adc_on, .dac_on, .conv_ready(rdy),
    .dac_data_r(dac_q));

  ////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  // mode then enables ref, clk, adc, dac, oe
  task st(input logic [2:0] m, input logic [4:0] e);
    chk(16'(mode), 16'(m));
    chk(16'({ref_on, cd_on, adc_on, dac_on, oe}), 16'(e));
  endtask
  // ready delay counted from end of the write, a few cycles of slack
  task wake(input int c);
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n > c - 12 && n < c + 4), 16'h1);
  endtask
  // dac inputs always driven
  // dac_in never floats; it holds a defined level between pulses
  task pulse(input logic [7:0] a, input logic [9:0] d);
    adc_word = a;
    dac_in = d;
    adc_word_valid = 1'b1;
    dac_in_valid = 1'b1;
    @(negedge clk);
    adc_word_valid = 1'b0;
    dac_in_valid = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////
  task t_reset;
    st(3'h0, 5'h00);
    chk(16'(dac_q), 16'h0000);
  endtask
  task t_xcvr;
    h.wr(8'h04, 8);
    st(3'h4, 5'h1F);
    wake(SLOW);
  endtask
  task t_switch;
    idle_hi = 1'b1;
    h.wr(8'hFA, 8);
    st(3'h2, 5'h1D);
    wake(FAST);
  endtask
  task t_bus;
    pulse(8'h5A, 10'h000);
    h.wr(8'h03, 8);
    st(3'h3, 5'h1A);
    pulse(8'h33, 10'h155);
    chk(16'(dac_q), 16'h0155);
    h.wr(8'h04, 8);
    chk(16'(bus_o), 16'h005A);
    wake(FAST);
  endtask
  task t_refuse;
    h.wr(8'h06, 8);
    h.wr(8'h07, 8);
    h.wr(8'h00, 5);
    st(3'h4, 5'h1F);
  endtask
  task t_idle;
    idle_hi = 1'b0;
    h.wr(8'h01, 8);
    st(3'h1, 5'h18);
    h.wr(8'h02, 8);
    wake(FAST);
    h.wr(8'h01, 8);
    run_cc = 1'b0;
    repeat (40) @(negedge clk);
    h.wr(8'h02, 8);
    wake(SLOW);
    run_cc = 1'b1;
  endtask
  task t_standby;
    h.wr(8'h05, 8);
    st(3'h5, 5'h10);
    h.wr(8'h04, 8);
    wake(SLOW);
  endtask
  task t_shut;
    h.wr(8'h00, 8);
    st(3'h0, 5'h00);
    h.wr(8'h03, 8);
    st(3'h3, 5'h1A);
    chk(16'(dac_q), 16'h0000);
    wake(SLOW);
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_xcvr();
    t_switch();
    t_bus();
    t_refuse();
    t_idle();
    t_standby();
    t_shut();
    complete_run();
  end
  // watchdog well beyond the summed recovery waits
  initial begin
    #1000000;
    num_errors++;
    complete_run();
  end
endmodule
